// ---- verilog/rphb_builder.sv ----
`timescale 1ns/1ns
`include "rphb_cfg.svh"

// Notes on behaviour
// - Every stored packet starts with an eight-byte header at offsets 0 to 7.
// - The serial engine writes header bytes 0 to 5 (endpoint, flags, PID, address, frame).
// - The serial engine DMA writes the byte-count bytes at offsets 6 and 7.
// - Byte 0 holds the endpoint in bits 3:0 and a zero in bit 4.
// - Byte 0 bit 7 is set when the packet had a bad CRC.
// - Byte 0 bit 6 holds the toggle of the packet received.
// - Byte 0 bit 5 is set when the toggle equals the previous one, else clear.
// - Frame count bits 7:0 go to byte 4, bits 15:8 to byte 5.
// - Byte count bits 7:0 go to byte 6, bits 10:8 to byte 7 bits 2:0, rest zero.
// - Payload starts at offset 8 and the byte count is payload size plus 8.
// - Any payload length from 0 to 1280 bytes is accepted.
module rphb_builder #(
    parameter int MAX_PAYLOAD = `RPHB_MAX_PAYLOAD
) (
    // Clock and reset
    input  wire logic                    I_CLK,
    input  wire logic                    I_RST,
    // Packet start from the receive path
    input  wire logic                    i_pkt_start,
    input  wire rphb_pkg::rphb_pkt_info_t i_pkt_info,
    // Payload stream
    input  wire logic                    i_data_valid,
    input  wire logic [7:0]              i_data,
    // Packet end with CRC result
    input  wire logic                    i_pkt_end,
    input  wire logic                    i_crc_bad,
    // Buffer RAM write port
    output logic                         O_MEM_WE,
    output logic [10:0]                  O_MEM_ADDR,
    output logic [7:0]                   O_MEM_DATA,
    // Completion
    output logic                         O_PKT_DONE,
    output logic                         O_PKT_OVERSIZE,
    output logic                         O_BUSY
);

    rphb_pkg::rphb_state_t    state_r;
    rphb_pkg::rphb_pkt_info_t info_r;
    logic [10:0]              count_r;
    logic [2:0]               hdr_idx_r;
    logic                     crc_bad_r;
    logic                     prev_tog_r;
    logic                     mismatch_r;
    logic                     oversize_r;
    rphb_pkg::rphb_mem_wr_t   wr_nxt;
    wire logic [7:0]          hdr_tab [8];

    // One past the last address a payload byte may use
    localparam logic [10:0] CNT_CAP = 11'(MAX_PAYLOAD) + `RPHB_HDR_LEN;

    // ------------------------------------------------------------------
    // Header byte encoder
    // ------------------------------------------------------------------
    function automatic logic [7:0] hdr_byte(
        input logic [2:0]               idx,
        input rphb_pkg::rphb_pkt_info_t info,
        input logic                     crc_bad,
        input logic                     mismatch,
        input logic [10:0]              count
    );
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            `RPHB_OFF_EP: begin
                b[3:0] = info.endpoint;
                b[`RPHB_BIT_CRC] = crc_bad;
                b[`RPHB_BIT_TOG] = info.toggle;
                b[`RPHB_BIT_MISMATCH] = mismatch;
            end
            `RPHB_OFF_PID:    b = {4'h0, info.pid};
            `RPHB_OFF_ADDR:   b = {1'b0, info.func_addr};
            `RPHB_OFF_RSVD:   b = `RPHB_RSVD_VAL;
            `RPHB_OFF_FRM_LO: b = info.frame_count[7:0];
            `RPHB_OFF_FRM_HI: b = info.frame_count[15:8];
            `RPHB_OFF_CNT_LO: b = count[7:0];
            `RPHB_OFF_CNT_HI: b = {5'h00, count[10:8]};
            default:          b = 8'h00;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Header byte table
    // ------------------------------------------------------------------
    // One entry per offset, so the write mux only has to index
    generate
        for (genvar g = 0; g < 8; g++) begin : g_hdr
            assign hdr_tab[g] = hdr_byte(3'(g), info_r, crc_bad_r, mismatch_r, count_r);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Shared decodes
    // ------------------------------------------------------------------
    // A start counts only in idle, the done-pulse cycle included; pulses in other states are refused
    function automatic logic start_taken(
        input rphb_pkg::rphb_state_t st,
        input logic                  start
    );
        return (st == rphb_pkg::RPHB_IDLE) && start;
    endfunction

    // The end pulse closes the payload and carries the CRC result
    function automatic logic end_taken(
        input rphb_pkg::rphb_state_t st,
        input logic                  pkt_end
    );
        return (st == rphb_pkg::RPHB_PAYLOAD) && pkt_end;
    endfunction

    // Data outside the payload state is ignored
    function automatic logic byte_taken(
        input rphb_pkg::rphb_state_t st,
        input logic                  valid
    );
        return (st == rphb_pkg::RPHB_PAYLOAD) && valid;
    endfunction

    // Both header phases write one byte per cycle
    function automatic logic in_header(input rphb_pkg::rphb_state_t st);
        return (st == rphb_pkg::RPHB_ENGHDR) || (st == rphb_pkg::RPHB_DMAHDR);
    endfunction

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_r <= rphb_pkg::RPHB_IDLE;
        end else begin
            case (state_r)
                rphb_pkg::RPHB_IDLE: begin
                    if (i_pkt_start) begin
                        state_r <= rphb_pkg::RPHB_PAYLOAD;
                    end
                end
                rphb_pkg::RPHB_PAYLOAD: begin
                    if (i_pkt_end) begin
                        state_r <= rphb_pkg::RPHB_ENGHDR;
                    end
                end
                rphb_pkg::RPHB_ENGHDR: begin
                    if (hdr_idx_r == `RPHB_LAST_ENGINE) begin
                        state_r <= rphb_pkg::RPHB_DMAHDR;
                    end
                end
                rphb_pkg::RPHB_DMAHDR: begin
                    if (hdr_idx_r == `RPHB_OFF_CNT_HI) begin
                        state_r <= rphb_pkg::RPHB_DONE;
                    end
                end
                rphb_pkg::RPHB_DONE: begin
                    state_r <= rphb_pkg::RPHB_IDLE;
                end
                default: begin
                    state_r <= rphb_pkg::RPHB_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Header offset: engine bytes 0 to 5, then DMA bytes 6 and 7
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            hdr_idx_r <= 3'h0;
        end else if (end_taken(state_r, i_pkt_end)) begin
            hdr_idx_r <= 3'h0;
        end else if (in_header(state_r)) begin
            hdr_idx_r <= hdr_idx_r + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Packet attributes
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            info_r <= '0;
        end else if (start_taken(state_r, i_pkt_start)) begin
            info_r <= i_pkt_info;
        end
    end

    // ------------------------------------------------------------------
    // Toggle history: a first packet with toggle 0 flags a mismatch
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            prev_tog_r <= 1'b0;
            mismatch_r <= 1'b0;
        end else if (start_taken(state_r, i_pkt_start)) begin
            mismatch_r <= (i_pkt_info.toggle == prev_tog_r);
            prev_tog_r <= i_pkt_info.toggle;
        end
    end

    // ------------------------------------------------------------------
    // CRC result of the packet in flight
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            crc_bad_r <= 1'b0;
        end else if (end_taken(state_r, i_pkt_end)) begin
            crc_bad_r <= i_crc_bad;
        end
    end

    // ------------------------------------------------------------------
    // Byte count: starts at header length so it ends as payload plus 8
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            count_r <= 11'h000;
        end else if (start_taken(state_r, i_pkt_start)) begin
            count_r <= `RPHB_HDR_LEN;
        end else if (byte_taken(state_r, i_data_valid) && count_r < CNT_CAP) begin
            count_r <= count_r + 11'h001;
        end
    end

    // ------------------------------------------------------------------
    // Oversize: bytes past the cap are dropped and flagged
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            oversize_r <= 1'b0;
        end else if (start_taken(state_r, i_pkt_start)) begin
            oversize_r <= 1'b0;
        end else if (byte_taken(state_r, i_data_valid) && count_r >= CNT_CAP) begin
            oversize_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Memory write selection
    // ------------------------------------------------------------------
    always_comb begin
        wr_nxt = '0;
        if (byte_taken(state_r, i_data_valid) && count_r < CNT_CAP) begin
            wr_nxt.we   = 1'b1;
            wr_nxt.addr = count_r;
            wr_nxt.data = i_data;
        end else if (in_header(state_r)) begin
            wr_nxt.we   = 1'b1;
            wr_nxt.addr = {8'h00, hdr_idx_r};
            wr_nxt.data = hdr_tab[hdr_idx_r];
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_MEM_WE   <= 1'b0;
            O_MEM_ADDR <= 11'h000;
            O_MEM_DATA <= 8'h00;
        end else begin
            O_MEM_WE   <= wr_nxt.we;
            O_MEM_ADDR <= wr_nxt.addr;
            O_MEM_DATA <= wr_nxt.data;
        end
    end

    // ------------------------------------------------------------------
    // Completion and status outputs
    // ------------------------------------------------------------------
    // Done pulses for one cycle once byte 7 has been presented
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PKT_DONE <= 1'b0;
        end else begin
            O_PKT_DONE <= (state_r == rphb_pkg::RPHB_DONE);
        end
    end

    // Oversize stays up until the next packet is taken
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PKT_OVERSIZE <= 1'b0;
        end else begin
            O_PKT_OVERSIZE <= oversize_r;
        end
    end

    // Busy covers the packet from the taken start to the done state
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_BUSY <= 1'b0;
        end else begin
            O_BUSY <= (state_r != rphb_pkg::RPHB_IDLE)
                      || start_taken(state_r, i_pkt_start);
        end
    end

endmodule

// ---- verilog/rphb_cfg.svh ----
`ifndef RPHB_CFG_SVH
`define RPHB_CFG_SVH

// ----------------------------------------------------------------------
// Header layout
// ----------------------------------------------------------------------
`define RPHB_HDR_LEN        11'h008
`define RPHB_OFF_EP         3'h0
`define RPHB_OFF_PID        3'h1
`define RPHB_OFF_ADDR       3'h2
`define RPHB_OFF_RSVD       3'h3
`define RPHB_OFF_FRM_LO     3'h4
`define RPHB_OFF_FRM_HI     3'h5
`define RPHB_OFF_CNT_LO     3'h6
`define RPHB_OFF_CNT_HI     3'h7
`define RPHB_LAST_ENGINE    3'h5
`define RPHB_BIT_CRC        7
`define RPHB_BIT_TOG        6
`define RPHB_BIT_MISMATCH   5
`define RPHB_RSVD_VAL       8'h00
`define RPHB_MAX_PAYLOAD    1280

`endif

// ---- verilog/rphb_pkg.sv ----
package rphb_pkg;

    // Packet attributes captured at packet start
    typedef struct packed {
        logic [3:0]  endpoint;
        logic [3:0]  pid;
        logic [6:0]  func_addr;
        logic [15:0] frame_count;
        logic        toggle;
    } rphb_pkt_info_t;

    // Write port toward the buffer RAM
    typedef struct packed {
        logic        we;
        logic [10:0] addr;
        logic [7:0]  data;
    } rphb_mem_wr_t;

    typedef enum logic [2:0] {
        RPHB_IDLE    = 3'b000,
        RPHB_PAYLOAD = 3'b001,
        RPHB_ENGHDR  = 3'b010,
        RPHB_DMAHDR  = 3'b011,
        RPHB_DONE    = 3'b100
    } rphb_state_t;

endpackage

// ---- verif/rphb_builder_properties.sv ----
`timescale 1ns/1ns
module rphb_builder_properties #(
    parameter int MAX_PAYLOAD = 1280
) (
    input wire logic                     I_CLK,
    input wire logic                     I_RST,
    input wire logic                     i_pkt_start,
    input wire rphb_pkg::rphb_pkt_info_t i_pkt_info,
    input wire logic                     i_data_valid,
    input wire logic [7:0]               i_data,
    input wire logic                     i_pkt_end,
    input wire logic                     i_crc_bad,
    input wire logic                     O_MEM_WE,
    input wire logic [10:0]              O_MEM_ADDR,
    input wire logic [7:0]               O_MEM_DATA,
    input wire logic                     O_PKT_DONE,
    input wire logic                     O_PKT_OVERSIZE,
    input wire logic                     O_BUSY
);
    logic                     pay_r, crc_r, old_r;
    logic [10:0]              cnt_r;
    rphb_pkg::rphb_pkt_info_t inf_r;
    wire logic [10:0]         tot = cnt_r + 11'h008;
    wire logic                hdr = O_MEM_WE && O_MEM_ADDR < 11'h008;
    wire logic [7:0]          a = O_MEM_ADDR[7:0];
    // Shadow of the packet in flight
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            {pay_r, crc_r, old_r, cnt_r, inf_r} <= '0;
        end else if (i_pkt_start && (!O_BUSY || O_PKT_DONE) && !pay_r) begin
            {pay_r, cnt_r, inf_r, old_r} <= {1'b1, 11'h000, i_pkt_info, inf_r.toggle};
        end else if (pay_r) begin
            cnt_r <= cnt_r + 11'(i_data_valid);
            if (i_pkt_end) begin
                {pay_r, crc_r} <= {1'b0, i_crc_bad};
            end
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    sequence hdr_walk;
        (O_MEM_WE && O_MEM_ADDR == 11'h000)
        ##1 (O_MEM_WE && O_MEM_ADDR == $past(O_MEM_ADDR) + 11'h001) [*7] ##1 O_PKT_DONE;
    endsequence
    a_hdr_order: assert property (pay_r && i_pkt_end |-> ##2 hdr_walk)
        else $error("header bytes out of order");
    a_payload_wr: assert property (pay_r && i_data_valid && cnt_r < MAX_PAYLOAD |=>
        O_MEM_WE && O_MEM_ADDR == $past(tot) && O_MEM_DATA == $past(i_data))
        else $error("payload byte misplaced");
    a_drop_extra: assert property (pay_r && i_data_valid && cnt_r >= MAX_PAYLOAD |=>
        !O_MEM_WE ##1 O_PKT_OVERSIZE) else $error("extra byte not dropped");
    a_count_lo: assert property (hdr && a == 8'h06 && !O_PKT_OVERSIZE |->
        O_MEM_DATA == tot[7:0]) else $error("count low wrong");
    a_count_hi: assert property (hdr && a == 8'h07 && !O_PKT_OVERSIZE |->
        O_MEM_DATA == {5'h00, tot[10:8]}) else $error("count high wrong");
    a_status_byte: assert property (hdr && a == 8'h00 |-> O_MEM_DATA[4:0] ==
        {1'b0, inf_r.endpoint} && O_MEM_DATA[7:6] == {crc_r, inf_r.toggle})
        else $error("status byte wrong");
    a_toggle_flag: assert property (hdr && a == 8'h00 |->
        O_MEM_DATA[5] == (inf_r.toggle == old_r)) else $error("toggle flag wrong");
    a_id_fields: assert property (hdr && a inside {8'h01, 8'h02} |-> O_MEM_DATA ==
        (a == 8'h01 ? {4'h0, inf_r.pid} : {1'b0, inf_r.func_addr}))
        else $error("id byte wrong");
    a_frame_bytes: assert property (hdr && a inside {8'h04, 8'h05} |-> O_MEM_DATA ==
        (a == 8'h04 ? inf_r.frame_count[7:0] : inf_r.frame_count[15:8]))
        else $error("frame byte wrong");
    a_rsvd_byte: assert property (hdr && a == 8'h03 |-> O_MEM_DATA == 8'h00)
        else $error("reserved byte wrong");
    a_done_pulse: assert property (O_PKT_DONE |-> O_BUSY ##1 !O_PKT_DONE)
        else $error("done not a single pulse");
    a_busy_span: assert property (pay_r |-> O_BUSY)
        else $error("busy low during packet");
endmodule
bind rphb_builder rphb_builder_properties #(.MAX_PAYLOAD(MAX_PAYLOAD)) u_props (.I_CLK(I_CLK),
    .I_RST(I_RST), .i_pkt_start(i_pkt_start), .i_pkt_info(i_pkt_info),
    .i_data_valid(i_data_valid), .i_data(i_data), .i_pkt_end(i_pkt_end),
    .i_crc_bad(i_crc_bad), .O_MEM_WE(O_MEM_WE), .O_MEM_ADDR(O_MEM_ADDR),
    .O_MEM_DATA(O_MEM_DATA), .O_PKT_DONE(O_PKT_DONE), .O_PKT_OVERSIZE(O_PKT_OVERSIZE),
    .O_BUSY(O_BUSY));

// ---- verif/rphb_host_model.sv ----
`timescale 1ns/1ns
module rphb_host_model (
    input  wire logic               I_CLK,
    output rphb_pkg::rphb_pkt_info_t o_pkt_info,
    output logic                    o_pkt_start,
    output logic                    o_data_valid,
    output logic [7:0]              o_data,
    output logic                    o_pkt_end,
    output logic                    o_crc_bad
);
    initial begin
        {o_pkt_start, o_data_valid, o_pkt_end, o_crc_bad} = 4'h0;
        o_pkt_info = '0;
        o_data = 8'h00;
    end
    task automatic send(input rphb_pkg::rphb_pkt_info_t info, input int n, input logic crc);
        @(negedge I_CLK);
        {o_pkt_start, o_pkt_info} = {1'b1, info};
        @(negedge I_CLK);
        // Released fields show garbage, not the old value
        {o_pkt_start, o_pkt_info} = {1'b0, ~info};
        for (int i = 0; i < n; i++) begin
            {o_data_valid, o_data} = {1'b1, 8'(i) ^ 8'h5a};
            @(negedge I_CLK);
        end
        {o_data_valid, o_data, o_pkt_end, o_crc_bad} = {1'b0, ~o_data, 1'b1, crc};
        @(negedge I_CLK);
        {o_pkt_end, o_crc_bad} = {1'b0, ~crc};
    endtask
endmodule

// ---- verif/rphb_builder_tb_top.sv ----
`timescale 1ns/1ns
module rphb_builder_tb_top;
    logic                     I_CLK, I_RST, start, valid, pend, crc, we, done, ovs, busy;
    logic [7:0]               din, dout;
    logic [10:0]              addr;
    rphb_pkg::rphb_pkt_info_t info;
    logic [7:0]               mem [0:2047];
    int                       failures = 0, num_checks = 0, cyc = 0;
    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end
    rphb_host_model host (.I_CLK(I_CLK), .o_pkt_info(info), .o_pkt_start(start),
        .o_data_valid(valid), .o_data(din), .o_pkt_end(pend), .o_crc_bad(crc));
    rphb_builder uut (.I_CLK(I_CLK), .I_RST(I_RST), .i_pkt_start(start), .i_pkt_info(info),
        .i_data_valid(valid), .i_data(din), .i_pkt_end(pend), .i_crc_bad(crc),
        .O_MEM_WE(we), .O_MEM_ADDR(addr), .O_MEM_DATA(dout), .O_PKT_DONE(done),
        .O_PKT_OVERSIZE(ovs), .O_BUSY(busy));
    // Buffer stand-in, written where the write port is settled
    always @(negedge I_CLK) begin
        if (we === 1'b1) mem[addr] <= dout;
    end
    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            test_done();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input rphb_pkg::rphb_pkt_info_t pi, input int n, input logic bad,
                       input logic mism);
        logic [10:0] tot;
        int          k;
        tot = 11'(n + 8);
        for (k = 0; k < 2048; k++) mem[k] = 8'hxx;
        host.send(pi, n, bad);
        chk({7'h00, busy}, 8'h01);
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge I_CLK);
        if (k == 3000) begin
            failures++;
            test_done();
        end
        @(negedge I_CLK);
        chk({6'h00, done, busy}, 8'h00);
        chk(mem[0], {bad, pi.toggle, mism, 1'b0, pi.endpoint});
        chk({4'h0, mem[0][3:0]}, {4'h0, pi.endpoint});
        chk(mem[1], {4'h0, pi.pid});
        chk(mem[2], {1'b0, pi.func_addr});
        chk(mem[3], 8'h00);
        chk(mem[4], pi.frame_count[7:0]);
        chk(mem[5], pi.frame_count[15:8]);
        if (n <= 1280) chk(mem[6], tot[7:0]);
        if (n <= 1280) chk(mem[7], {5'h00, tot[10:8]});
        for (k = 0; k < n && k < 1280; k++) chk(mem[8 + k], 8'(k) ^ 8'h5a);
        chk({7'h00, ovs}, {7'h00, 1'(n > 1280)});
    endtask
    task t_first;
        run({4'ha, 4'hd, 7'h5b, 16'hf3c7, 1'b0}, 3, 1'b0, 1'b1);
        $display("test first done");
    endtask
    task t_toggle;
        run({4'h3, 4'h9, 7'h01, 16'h07ff, 1'b1}, 0, 1'b1, 1'b0);
        run({4'hf, 4'h1, 7'h7f, 16'h0800, 1'b1}, 1, 1'b0, 1'b1);
        $display("test toggle done");
    endtask
    task t_max;
        run({4'h0, 4'h5, 7'h00, 16'hffff, 1'b0}, 1280, 1'b0, 1'b0);
        run({4'h7, 4'h2, 7'h2a, 16'h0001, 1'b1}, 1281, 1'b0, 1'b0);
        chk(mem[1288], 8'hxx);
        $display("test max done");
    endtask
    task test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        I_RST = 1'b1;
        repeat (5) @(posedge I_CLK);
        @(negedge I_CLK);
        I_RST = 1'b0;
        t_first();
        t_toggle();
        t_max();
        test_done();
    end
endmodule
